// >>> src/tps_pkg.sv
// shared constants for the timer prescaler and external count block
// assumes a 32-bit AHB-Lite register bus and one 200 MHz clock
package tps_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] TPS_OFF_CTRL = 8'h00;
	localparam logic [7:0] TPS_OFF_SEL0 = 8'h04;
	localparam logic [7:0] TPS_OFF_SEL1 = 8'h08;
	localparam logic [7:0] TPS_OFF_CNT0 = 8'h0c;
	localparam logic [7:0] TPS_OFF_CNT1 = 8'h10;
	localparam logic [7:0] TPS_OFF_PRE = 8'h14;

	// ----------------------------------------
	// control register fields and resets
	// ----------------------------------------
	localparam int TPS_BIT_HOLD = 7;
	localparam int TPS_BIT_PSR = 0;
	localparam logic TPS_RST_HOLD = 1'b0;
	localparam logic TPS_RST_PSR = 1'b0;

	// ----------------------------------------
	// widths and counter resets
	// ----------------------------------------
	localparam int TPS_NCH = 2;
	localparam int TPS_CNT_W = 16;
	localparam int TPS_PRE_W = 10;
	localparam int TPS_SEL_W = 3;
	localparam logic [15:0] TPS_RST_CNT = 16'h0000;
	localparam logic [9:0] TPS_RST_PRE = 10'h000;

	// ----------------------------------------
	// tap masks: tap fires when masked bits are all ones
	// ----------------------------------------
	localparam logic [9:0] TPS_MASK_8 = 10'h007;
	localparam logic [9:0] TPS_MASK_64 = 10'h03f;
	localparam logic [9:0] TPS_MASK_256 = 10'h0ff;
	localparam logic [9:0] TPS_MASK_1024 = 10'h3ff;

	// ----------------------------------------
	// count source selection
	// ----------------------------------------
	typedef enum logic [2:0] {
		TPS_SRC_OFF = 3'b000,
		TPS_SRC_CLK = 3'b001,
		TPS_SRC_D8 = 3'b010,
		TPS_SRC_D64 = 3'b011,
		TPS_SRC_D256 = 3'b100,
		TPS_SRC_D1024 = 3'b101,
		TPS_SRC_EXTFALL = 3'b110,
		TPS_SRC_EXTRISE = 3'b111
	} tps_src_t;
	localparam logic [2:0] TPS_RST_SEL = 3'b000;

endpackage

// >>> src/timer_prescaler_extclk_sync.sv
// shared prescaler, two counters and external count pin sampling
// assumes: single AHB-Lite master, count pins asynchronous to clk
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module tps_timer_prescaler_extclk_sync
	import tps_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// external count pins, one per counter
	input wire logic [1:0] extCountPin,
	// counter state
	output logic [15:0] countValue0,
	output logic [15:0] countValue1,
	output logic [1:0] timerCountClock
);

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	logic wrPend_r;
	logic wrPend_nxt;
	logic [7:0] wrAddr_r;
	logic [7:0] wrAddr_nxt;
	logic [31:0] rdData_r;
	logic [31:0] rdData_nxt;
	logic addrPhase;
	logic [31:0] rdMux;

	// ----------------------------------------
	// control register and prescaler
	// ----------------------------------------
	logic syncHoldMode_r;
	logic syncHoldMode_nxt;
	logic prescalerResetBit_r;
	logic prescalerResetBit_nxt;
	logic [9:0] pre_r;
	logic [9:0] pre_nxt;
	logic [4:0] tap;
	logic countHalt;
	logic ctrlWr;

	// ----------------------------------------
	// per channel state
	// ----------------------------------------
	logic [2:0] sel_r [TPS_NCH];
	logic [15:0] cnt_r [TPS_NCH];
	logic [TPS_NCH-1:0] pinLatch;
	logic [TPS_NCH-1:0] pinSync_r;
	logic [TPS_NCH-1:0] pinSync_nxt;
	logic [TPS_NCH-1:0] pinSafe_r;
	logic [TPS_NCH-1:0] pinSafe_nxt;
	logic [TPS_NCH-1:0] pinPrev_r;
	logic [TPS_NCH-1:0] pinPrev_nxt;
	logic [TPS_NCH-1:0] tick;

	// zero wait states, never an error
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdData_r;
	assign countValue0 = cnt_r[0];
	assign countValue1 = cnt_r[1];
	assign timerCountClock = tick;

	assign addrPhase = hsel & htrans[1] & hready;
	assign ctrlWr = wrPend_r & (wrAddr_r == TPS_OFF_CTRL);

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	always_comb begin
		rdMux = 32'h0000_0000;
		case (haddr[7:0])
			TPS_OFF_CTRL: begin
				rdMux[TPS_BIT_HOLD] = syncHoldMode_r;
				rdMux[TPS_BIT_PSR] = prescalerResetBit_r;
			end
			TPS_OFF_SEL0: begin
				rdMux[2:0] = sel_r[0];
			end
			TPS_OFF_SEL1: begin
				rdMux[2:0] = sel_r[1];
			end
			TPS_OFF_CNT0: begin
				rdMux[15:0] = cnt_r[0];
			end
			TPS_OFF_CNT1: begin
				rdMux[15:0] = cnt_r[1];
			end
			TPS_OFF_PRE: begin
				rdMux[9:0] = pre_r;
			end
			default: begin
				rdMux = 32'h0000_0000;
			end
		endcase
		if (haddr[31:8] != 24'h00_0000) begin
			rdMux = 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// bus phase tracking
	// ----------------------------------------
	// reads are answered from the address phase, so a read right
	// behind a write returns the value from before that write
	always_comb begin
		wrPend_nxt = addrPhase & hwrite;
		wrAddr_nxt = wrAddr_r;
		rdData_nxt = rdData_r;
		if (addrPhase) begin
			wrAddr_nxt = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
		end
		if (addrPhase & !hwrite) begin
			rdData_nxt = rdMux;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			rdData_r <= 32'h0000_0000;
		end else begin
			wrPend_r <= wrPend_nxt;
			wrAddr_r <= wrAddr_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	// a write stores both bits; between writes the reset bit
	// survives only while the hold bit is set
	always_comb begin
		syncHoldMode_nxt = syncHoldMode_r;
		prescalerResetBit_nxt = prescalerResetBit_r & syncHoldMode_r;
		if (ctrlWr) begin
			syncHoldMode_nxt = hwdata[TPS_BIT_HOLD];
			prescalerResetBit_nxt = hwdata[TPS_BIT_PSR];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			syncHoldMode_r <= TPS_RST_HOLD;
			prescalerResetBit_r <= TPS_RST_PSR;
		end else begin
			syncHoldMode_r <= syncHoldMode_nxt;
			prescalerResetBit_r <= prescalerResetBit_nxt;
		end
	end

	// counters stand still while the reset is held in hold mode
	assign countHalt = syncHoldMode_r & prescalerResetBit_r;

	// ----------------------------------------
	// shared free-running prescaler
	// ----------------------------------------
	// the clk source bypasses the prescaler, so only a reset held in hold mode stops it;
	// a lone reset bit just realigns the taps
	always_comb begin
		pre_nxt = pre_r + 10'h001;
		if (prescalerResetBit_r) begin
			pre_nxt = TPS_RST_PRE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_r <= TPS_RST_PRE;
		end else begin
			pre_r <= pre_nxt;
		end
	end

	// taps depend only on prescaler phase, never on a select
	always_comb begin
		tap[0] = 1'b1;
		tap[1] = (pre_r & TPS_MASK_8) == TPS_MASK_8;
		tap[2] = (pre_r & TPS_MASK_64) == TPS_MASK_64;
		tap[3] = (pre_r & TPS_MASK_256) == TPS_MASK_256;
		tap[4] = (pre_r & TPS_MASK_1024) == TPS_MASK_1024;
	end

	// ----------------------------------------
	// per channel sampling, select and counter
	// ----------------------------------------
	genvar ch;
	generate
		for (ch = 0; ch < TPS_NCH; ch++) begin : g_ch
			logic [2:0] selNxt;
			logic [15:0] cntNxt;
			logic extEdge;
			logic selWr;
			logic cntWr;

			assign selWr = wrPend_r & (wrAddr_r == (ch == 0 ? TPS_OFF_SEL0 : TPS_OFF_SEL1));
			assign cntWr = wrPend_r & (wrAddr_r == (ch == 0 ? TPS_OFF_CNT0 : TPS_OFF_CNT1));

			// ----------------------------------------
			// pin synchroniser
			// ----------------------------------------
			// latch open in the high half, so the pin settles
			// half a cycle before the first flip-flop samples it
			always_latch begin
				if (clk) begin
					pinLatch[ch] <= extCountPin[ch];
				end
			end

			// second flop gives the edge detector a settled level and
			// puts the counter update 2.5 to 3.5 cycles after the pin edge
			always_comb begin
				pinSync_nxt[ch] = pinLatch[ch];
				pinSafe_nxt[ch] = pinSync_r[ch];
				pinPrev_nxt[ch] = pinSafe_r[ch];
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					pinSync_r[ch] <= 1'b0;
					pinSafe_r[ch] <= 1'b0;
					pinPrev_r[ch] <= 1'b0;
				end else begin
					pinSync_r[ch] <= pinSync_nxt[ch];
					pinSafe_r[ch] <= pinSafe_nxt[ch];
					pinPrev_r[ch] <= pinPrev_nxt[ch];
				end
			end

			// ----------------------------------------
			// edge detector
			// ----------------------------------------
			// a level change seen at select time can fake one edge
			always_comb begin
				extEdge = 1'b0;
				if (sel_r[ch] == TPS_SRC_EXTRISE) begin
					extEdge = pinSafe_r[ch] & !pinPrev_r[ch];
				end
				if (sel_r[ch] == TPS_SRC_EXTFALL) begin
					extEdge = !pinSafe_r[ch] & pinPrev_r[ch];
				end
			end

			// ----------------------------------------
			// count source and counter
			// ----------------------------------------
			// a tap picked mid-phase first fires 1 to N cycles later;
			// the reset bit lines counting up with software
			always_comb begin
				case (sel_r[ch])
					TPS_SRC_OFF: begin
						tick[ch] = 1'b0;
					end
					TPS_SRC_CLK: begin
						tick[ch] = tap[0] & !countHalt;
					end
					TPS_SRC_D8: begin
						tick[ch] = tap[1] & !countHalt;
					end
					TPS_SRC_D64: begin
						tick[ch] = tap[2] & !countHalt;
					end
					TPS_SRC_D256: begin
						tick[ch] = tap[3] & !countHalt;
					end
					TPS_SRC_D1024: begin
						tick[ch] = tap[4] & !countHalt;
					end
					TPS_SRC_EXTFALL: begin
						tick[ch] = extEdge & !countHalt;
					end
					TPS_SRC_EXTRISE: begin
						tick[ch] = extEdge & !countHalt;
					end
					default: begin
						tick[ch] = 1'b0;
					end
				endcase
			end

			always_comb begin
				selNxt = sel_r[ch];
				cntNxt = cnt_r[ch];
				if (selWr) begin
					selNxt = hwdata[2:0];
				end
				if (tick[ch]) begin
					cntNxt = cnt_r[ch] + 16'h0001;
				end
				if (cntWr) begin
					cntNxt = hwdata[15:0];
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					sel_r[ch] <= TPS_RST_SEL;
					cnt_r[ch] <= TPS_RST_CNT;
				end else begin
					sel_r[ch] <= selNxt;
					cnt_r[ch] <= cntNxt;
				end
			end
		end
	endgenerate

endmodule // tps_timer_prescaler_extclk_sync

`default_nettype wire

// >>> dv/tps_monitor.sv
// port assertions for the prescaler block
// assumes a zero wait-state bus and one clock
`timescale 1ns/1ps
`default_nettype none
module tps_monitor
	import tps_pkg::*;
(
	// clock, reset, bus
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// counting
	input wire logic [1:0] extCountPin,
	input wire logic [15:0] countValue0,
	input wire logic [1:0] timerCountClock
);
	// ----
	// shadow of written state
	// ----
	logic wr_r, rd_r, hold_r, psr_r;
	logic [7:0] adr_r;
	logic [2:0] sel_r;
	wire logic wc = wr_r && adr_r == TPS_OFF_CTRL;
	wire logic ld0 = wr_r && adr_r == TPS_OFF_CNT0;
	wire logic halt = hold_r && psr_r;
	always_ff @(posedge clk) begin
		wr_r <= !rst && hsel && htrans[1] && hwrite;
		rd_r <= !rst && hsel && htrans[1] && !hwrite;
		adr_r <= haddr[7:0];
		hold_r <= !rst && (wc ? hwdata[7] : hold_r);
		// reset bit lives one cycle unless hold keeps it
		psr_r <= !rst && (wc ? hwdata[0] : psr_r && hold_r);
		if (rst) sel_r <= 3'h0;
		else if (wr_r && adr_r == TPS_OFF_SEL0) sel_r <= hwdata[2:0];
	end
	// ----
	// properties
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence quietD8;
		(!timerCountClock[0]) [*7];
	endsequence
	a_ctrl_read: assert property (rd_r && adr_r == TPS_OFF_CTRL |->
		hrdata == {24'h0, $past(hold_r), 6'h0, $past(psr_r)}) else $error("control read");
	a_count_step: assert property (timerCountClock[0] && !ld0 |=>
		countValue0 == $past(countValue0) + 16'h1) else $error("count step");
	a_count_still: assert property (!timerCountClock[0] && !ld0 |=>
		$stable(countValue0)) else $error("count moved");
	a_halt_none: assert property (halt |-> !timerCountClock)
		else $error("halted count");
	a_clk_src: assert property (sel_r == TPS_SRC_CLK && !halt |-> timerCountClock[0])
		else $error("clock source");
	a_tap_gap: assert property (sel_r == TPS_SRC_D8 && timerCountClock[0] |=> quietD8)
		else $error("tap gap");
	a_ext_rise: assert property (sel_r == TPS_SRC_EXTRISE && $rose(extCountPin[0])
		|-> ##[2:3] timerCountClock[0]) else $error("edge lost");
	a_ext_once: assert property (sel_r[2:1] == 2'b11 && timerCountClock[0] |=>
		!timerCountClock[0]) else $error("double pulse");
endmodule // tps_monitor
bind tps_timer_prescaler_extclk_sync tps_monitor i_mon (
	.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hrdata(hrdata), .extCountPin(extCountPin),
	.countValue0(countValue0), .timerCountClock(timerCountClock));
`default_nettype wire

// >>> dv/tps_ext_src.sv
// square wave source on one count pin
// assumes the pin is sampled on rising clk
`timescale 1ns/1ps
`default_nettype none
module tps_ext_src #(
	parameter int HALF = 4
) (
	// clock and gate
	input wire logic clk,
	input wire logic run,
	// pin
	output logic pin
);
	// ----
	// toggling
	// ----
	int n = 0;
	initial pin = 1'b0;
	// pin moves on the rising edge, so each phase is HALF whole cycles
	always @(posedge clk) begin
		if (run) begin
			n = n + 1;
			if (n == HALF) begin
				n = 0;
				pin <= ~pin;
			end
		end
	end
endmodule // tps_ext_src
`default_nettype wire

// >>> dv/tps_timer_prescaler_extclk_sync_tb.sv
// bench: source rows, then control register cases
// assumes the design answers the bus with no wait states
`timescale 1ns/1ps
`default_nettype none
module tps_timer_prescaler_extclk_sync_tb
	import tps_pkg::*;
;
	typedef struct {logic [2:0] s0, s1; logic [15:0] e0, e1;} tps_row_t;
	tps_row_t rows [6] = '{
		'{TPS_SRC_OFF, TPS_SRC_CLK, 16'h0, 16'h400},
		'{TPS_SRC_D8, TPS_SRC_D64, 16'h80, 16'h10},
		'{TPS_SRC_D256, TPS_SRC_D1024, 16'h4, 16'h1},
		'{TPS_SRC_EXTRISE, TPS_SRC_EXTFALL, 16'h80, 16'h40},
		'{TPS_SRC_EXTFALL, TPS_SRC_EXTRISE, 16'h80, 16'h40},
		'{TPS_SRC_CLK, TPS_SRC_OFF, 16'h400, 16'h0}};
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [1:0] htrans = 2'h0, run = 2'h0, timerCountClock;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [15:0] countValue0, countValue1, c0, c1;
	wire logic [1:0] extCountPin;
	int n_fail = 0, checks_done = 0, cyc = 0;
	tps_timer_prescaler_extclk_sync i_dut (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .extCountPin(extCountPin),
		.countValue0(countValue0), .countValue1(countValue1), .timerCountClock(timerCountClock));
	tps_ext_src #(.HALF(4)) i_src0 (.clk(clk), .run(run[0]), .pin(extCountPin[0]));
	tps_ext_src #(.HALF(8)) i_src1 (.clk(clk), .run(run[1]), .pin(extCountPin[1]));
	// ----
	// tasks
	// ----
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done = checks_done + 1;
		if (s !== e) begin
			n_fail = n_fail + 1;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 9000) begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end
	// ----
	// cases
	// ----
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1 chk("counts", 32'h0, {countValue1, countValue0});
		rdc(TPS_OFF_CTRL, 32'h0, "ctrl");
		foreach (rows[i]) begin
			bus(1'b1, TPS_OFF_SEL0, {29'h0, rows[i].s0});
			bus(1'b1, TPS_OFF_SEL1, {29'h0, rows[i].s1});
			run <= {2{rows[i].s0[2:1] == 2'b11}};
			repeat (8) @(posedge clk);
			#1 c0 = countValue0;
			c1 = countValue1;
			repeat (1024) @(posedge clk);
			#1 chk("delta0", {16'h0, rows[i].e0}, {16'h0, countValue0 - c0});
			chk("delta1", {16'h0, rows[i].e1}, {16'h0, countValue1 - c1});
			run <= 2'h0;
			repeat (8) @(posedge clk);
		end
		// read spacing fixes the expected prescaler step at 6 cycles
		bus(1'b0, TPS_OFF_PRE, 32'h0);
		c0 = rd[15:0];
		bus(1'b1, TPS_OFF_SEL1, {29'h0, TPS_SRC_D64});
		bus(1'b0, TPS_OFF_PRE, 32'h0);
		chk("pre step", 32'h6, (rd - {16'h0, c0}) & 32'h3ff);
		bus(1'b1, TPS_OFF_CTRL, 32'h81);
		#1 c0 = countValue0;
		rdc(TPS_OFF_CTRL, 32'h81, "ctrl hold");
		rdc(TPS_OFF_PRE, 32'h0, "pre held");
		#1 chk("halted", {16'h0, c0}, {16'h0, countValue0});
		bus(1'b1, TPS_OFF_CTRL, 32'hff);
		rdc(TPS_OFF_CTRL, 32'h81, "ctrl unused");
		bus(1'b1, TPS_OFF_CTRL, 32'h0);
		rdc(TPS_OFF_CTRL, 32'h0, "ctrl release");
		#1 c0 = countValue0;
		repeat (16) @(posedge clk);
		#1 chk("running", {16'h0, c0 + 16'h10}, {16'h0, countValue0});
		bus(1'b1, TPS_OFF_CTRL, 32'h1);
		rdc(TPS_OFF_CTRL, 32'h0, "ctrl clear");
		bus(1'b0, TPS_OFF_PRE, 32'h0);
		chk("pre restart", 32'h1, {31'h0, rd < 32'h8});
		bus(1'b1, 8'h40, 32'hffffffff);
		rdc(8'h40, 32'h0, "unmapped");
		// counter 0 still counts clk: the load wins, one tick follows
		bus(1'b1, TPS_OFF_CNT0, 32'h1234);
		rdc(TPS_OFF_CNT0, 32'h1235, "load beats tick");
		bus(1'b1, TPS_OFF_SEL1, 32'h0);
		bus(1'b1, TPS_OFF_CNT1, 32'habcd);
		rdc(TPS_OFF_CNT1, 32'habcd, "load idle");
		rdc(TPS_OFF_SEL0, {29'h0, TPS_SRC_CLK}, "sel0");
		chk("resp", 32'h0, {31'h0, hresp});
		stop_test();
	end
endmodule // tps_timer_prescaler_extclk_sync_tb
`default_nettype wire
